// ==== design/sff_map.vh ====
`ifndef SFF_MAP_VH
`define SFF_MAP_VH
// ============================================================
// register map (avalon word addresses are byte offsets / 4)
`define SFF_REG_CTRL      4'h0
`define SFF_REG_STATE     4'h1
`define SFF_REG_TAG_LO    4'h2
`define SFF_REG_TAG_HI    4'h3
`define SFF_REG_FRAME_CNT 4'h4
`define SFF_REG_TIMECODE  4'h5
`define SFF_REG_STATUS    4'h6
// ctrl fields
`define SFF_CTRL_ENABLE   0
`define SFF_CTRL_COUNTERS 1
`define SFF_CTRL_VALID    2
`define SFF_CTRL_DECI_LO  4
`define SFF_CTRL_ACC_LO   8
`define SFF_CTRL_FREQ_LO  20
// ============================================================
// header constants
`define SFF_MARKER        8'h5a
`define SFF_VERSION       8'h01
`define SFF_FFT_LEN_LOG2  8'h12
`define SFF_HDR_BYTES     24
`define SFF_BODY_BYTES    32768
`define SFF_VALUES        4096
`define SFF_TIMECODE_BITS 32
// ============================================================
// 8b10b control characters (k flag set)
`define SFF_K28_7         8'hfc
`define SFF_K23_7         8'hf7
// ============================================================
// link and timing
`define SFF_LINE_MBPS     1960
`define SFF_CLK_MHZ       100
`define SFF_RD_LATENCY    1
`endif

// ==== design/sff_timecode_capture.v ====
`include "sff_map.vh"
// ============================================================
// time-code capture: shifts in the signalling bit of each word
module sff_timecode_capture #(
  parameter WORD_BITS = 28,
  parameter TAG_BITS  = 32
) (
  input  wire                 core_clk_in,
  input  wire                 rst_b_in,
  input  wire [WORD_BITS-1:0] word_in,
  input  wire                 word_valid_in,
  output wire [TAG_BITS-1:0]  tag_out
);
  reg [TAG_BITS-1:0] shift_r; // last TAG_BITS signalling bits

  // ============================================================
  // only the msb is used; every other bit of the word is ignored
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      shift_r <= {TAG_BITS{1'b0}};
    end else if (word_valid_in) begin
      // newest bit lands in bit 0
      shift_r <= {shift_r[TAG_BITS-2:0], word_in[WORD_BITS-1]};
    end
  end

  assign tag_out = shift_r;
endmodule // sff_timecode_capture

// ==== design/sff_lane_tx.v ====
`include "sff_map.vh"
// ============================================================
// lane byte stage: one per polarization, carries byte plus k flag
module sff_lane_tx (
  input  wire       core_clk_in,
  input  wire       rst_b_in,
  input  wire [7:0] byte_in,
  input  wire       is_k_in,
  output reg  [7:0] lane_byte_out,
  output reg        lane_k_out
);
  // ============================================================
  // registered byte; 8b10b coding and serialising sit downstream
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lane_byte_out <= `SFF_K23_7; // idle from reset
      lane_k_out    <= 1'b1;
    end else begin
      lane_byte_out <= byte_in;
      lane_k_out    <= is_k_in;
    end
  end
endmodule // sff_lane_tx

// ==== design/sff_frame_formatter.v ====
// Function
// - frame opens with comma k28.7
// - idle k23.7 fills between frames
// - each lane runs one-way at 1960 mbit/s
// - first header byte is marker 5a
// - version byte is 01
// - flags: counters bit0, valid bit1, zeros
// - transform length byte fixed 12
// - state: enable, deci, 00, freq
// - two-byte accumulation count field
// - eight-byte tag passed through unchanged
// - frame counter increments once per frame
// - four bytes of captured time code
// - 32768-byte body, 4096 little-endian values
// - time code from msb of 32 words
// - each path has its own lane
// - freq counts 98 mhz/1024 steps
// - 12-bit accumulation, zero means complex
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`include "sff_map.vh"
module sff_frame_formatter #(
  parameter LANES     = 2,
  parameter WORD_BITS = 28
) (
  input  wire                 core_clk_in,
  input  wire                 rst_b_in,
  // avalon-mm slave
  input  wire [3:0]           avs_address_in,
  input  wire                 avs_read_in,
  input  wire                 avs_write_in,
  input  wire [31:0]          avs_writedata_in,
  input  wire [3:0]           avs_byteenable_in,
  output reg  [31:0]          avs_readdata_out,
  output wire                 avs_waitrequest_out,
  // sample stream for time-code capture
  input  wire [WORD_BITS-1:0] sample_word_in,
  input  wire                 sample_valid_in,
  // body source: one byte per lane per cycle while requested
  input  wire [8*LANES-1:0]   body_byte_in,
  input  wire                 body_ready_in,
  output wire                 body_req_out,
  output wire                 frame_start_out,
  // lane outputs, one byte plus k flag per lane
  output wire [8*LANES-1:0]   lane_byte_out,
  output wire [LANES-1:0]     lane_k_out
);
  // ============================================================
  // states
  localparam ST_IDLE  = 2'd0;
  localparam ST_COMMA = 2'd1;
  localparam ST_HDR   = 2'd2;
  localparam ST_BODY  = 2'd3;
  // line bytes per core cycle is 1960/10/100; downstream gearbox absorbs
  localparam LINE_BYTES_X100 = `SFF_LINE_MBPS / 10;

  // ============================================================
  // registers
  reg  [31:0] ctrl_r;        // enable, flags, deci, accum, freq
  reg  [31:0] tag_lo_r;      // tag bits 31:0
  reg  [31:0] tag_hi_r;      // tag bits 63:32
  reg  [31:0] frame_cnt_r;   // frames emitted
  reg  [31:0] frame_code_r;  // time code latched at frame start
  reg  [1:0]  state_r;       // frame sequencer state
  reg  [1:0]  state_nxt;
  reg  [14:0] cnt_r;         // byte index within header or body
  reg  [14:0] cnt_nxt;
  reg  [31:0] frames_done_r; // status: frames completed
  reg         rd_pend_r;     // read answer pending one cycle
  reg  [7:0]  hdr_byte;      // current header byte
  reg  [8*LANES-1:0] tx_byte; // byte to each lane
  reg         tx_k;           // control character flag
  wire [31:0] timecode;       // live capture
  wire [15:0] state_word;     // packed state field
  wire [7:0]  flags_byte;
  wire [11:0] accum;
  wire [31:0] bus_mask;
  integer     i;

  // ============================================================
  // field extraction
  assign accum = ctrl_r[`SFF_CTRL_ACC_LO +: 12];
  assign flags_byte = {6'h00, ctrl_r[`SFF_CTRL_VALID],
                       ctrl_r[`SFF_CTRL_COUNTERS]};
  // freq counts base steps of 98 mhz/1024, passed as is
  assign state_word = {ctrl_r[`SFF_CTRL_ENABLE],
                     ctrl_r[`SFF_CTRL_DECI_LO +: 3], 2'b00,
                     ctrl_r[`SFF_CTRL_FREQ_LO +: 10]};
  assign bus_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                     {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  // ============================================================
  // time-code capture
  sff_timecode_capture #(
    .WORD_BITS (WORD_BITS),
    .TAG_BITS  (`SFF_TIMECODE_BITS)
  ) u_tc (
    .core_clk_in   (core_clk_in),
    .rst_b_in      (rst_b_in),
    .word_in       (sample_word_in),
    .word_valid_in (sample_valid_in),
    .tag_out       (timecode)
  );

  // ============================================================
  // avalon slave: writes zero-wait, reads one wait cycle
  assign avs_waitrequest_out = avs_read_in & ~rd_pend_r;

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_r    <= 32'h0000_0000;
      tag_lo_r  <= 32'h0000_0000;
      tag_hi_r  <= 32'h0000_0000;
      rd_pend_r <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      // pending drops after the answering edge
      rd_pend_r <= avs_read_in & ~rd_pend_r;
      if (avs_write_in) begin
        case (avs_address_in)
          `SFF_REG_CTRL: begin
            ctrl_r <= (ctrl_r & ~bus_mask) | (avs_writedata_in & bus_mask);
          end
          `SFF_REG_TAG_LO: begin
            tag_lo_r <= (tag_lo_r & ~bus_mask) |
                        (avs_writedata_in & bus_mask);
          end
          `SFF_REG_TAG_HI: begin
            tag_hi_r <= (tag_hi_r & ~bus_mask) |
                        (avs_writedata_in & bus_mask);
          end
          default: begin
            // read-only or unmapped: write ignored
          end
        endcase
      end
      if (avs_read_in & ~rd_pend_r) begin
        case (avs_address_in)
          `SFF_REG_CTRL:      avs_readdata_out <= ctrl_r;
          `SFF_REG_STATE:     avs_readdata_out <= {16'h0000, state_word};
          `SFF_REG_TAG_LO:    avs_readdata_out <= tag_lo_r;
          `SFF_REG_TAG_HI:    avs_readdata_out <= tag_hi_r;
          `SFF_REG_FRAME_CNT: avs_readdata_out <= frame_cnt_r;
          `SFF_REG_TIMECODE:  avs_readdata_out <= timecode;
          `SFF_REG_STATUS: begin
            avs_readdata_out <= {frames_done_r[29:0], state_r};
          end
          default:            avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ============================================================
  // header byte mux, big-endian multi-byte fields
  always @* begin
    case (cnt_r[4:0])
      5'd0:  hdr_byte = `SFF_MARKER;
      5'd1:  hdr_byte = `SFF_VERSION;
      5'd2:  hdr_byte = flags_byte;
      5'd3:  hdr_byte = `SFF_FFT_LEN_LOG2;
      5'd4:  hdr_byte = state_word[15:8];
      5'd5:  hdr_byte = state_word[7:0];
      5'd6:  hdr_byte = {4'h0, accum[11:8]};
      5'd7:  hdr_byte = accum[7:0];
      5'd8:  hdr_byte = tag_hi_r[31:24];
      5'd9:  hdr_byte = tag_hi_r[23:16];
      5'd10: hdr_byte = tag_hi_r[15:8];
      5'd11: hdr_byte = tag_hi_r[7:0];
      5'd12: hdr_byte = tag_lo_r[31:24];
      5'd13: hdr_byte = tag_lo_r[23:16];
      5'd14: hdr_byte = tag_lo_r[15:8];
      5'd15: hdr_byte = tag_lo_r[7:0];
      5'd16: hdr_byte = frame_cnt_r[31:24];
      5'd17: hdr_byte = frame_cnt_r[23:16];
      5'd18: hdr_byte = frame_cnt_r[15:8];
      5'd19: hdr_byte = frame_cnt_r[7:0];
      5'd20: hdr_byte = frame_code_r[31:24];
      5'd21: hdr_byte = frame_code_r[23:16];
      5'd22: hdr_byte = frame_code_r[15:8];
      default: hdr_byte = frame_code_r[7:0];
    endcase
  end

  // ============================================================
  // sequencer next state; body_ready_in is checked only in idle, so the body never stalls
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    tx_k      = 1'b1;
    for (i = 0; i < LANES; i = i + 1) begin
      tx_byte[8*i +: 8] = `SFF_K23_7;
    end
    case (state_r)
      ST_IDLE: begin
        if (ctrl_r[`SFF_CTRL_ENABLE] & body_ready_in) begin
          state_nxt = ST_COMMA;
        end
      end
      ST_COMMA: begin
        for (i = 0; i < LANES; i = i + 1) begin
          tx_byte[8*i +: 8] = `SFF_K28_7;
        end
        state_nxt = ST_HDR;
        cnt_nxt   = 15'd0;
      end
      ST_HDR: begin
        tx_k = 1'b0;
        for (i = 0; i < LANES; i = i + 1) begin
          tx_byte[8*i +: 8] = hdr_byte;
        end
        if (cnt_r == `SFF_HDR_BYTES - 1) begin
          state_nxt = ST_BODY;
          cnt_nxt   = 15'd0;
        end else begin
          cnt_nxt = cnt_r + 15'd1;
        end
      end
      ST_BODY: begin
        // source presents little-endian value bytes in order
        tx_k    = 1'b0;
        tx_byte = body_byte_in;
        if (cnt_r == `SFF_BODY_BYTES - 1) begin
          state_nxt = ST_IDLE;
          cnt_nxt   = 15'd0;
        end else begin
          cnt_nxt = cnt_r + 15'd1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  assign body_req_out    = (state_r == ST_BODY);
  assign frame_start_out = (state_r == ST_COMMA);

  // ============================================================
  // sequencer state and per-frame counters
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r       <= ST_IDLE;
      cnt_r         <= 15'd0;
      frame_cnt_r   <= 32'h0000_0000;
      frame_code_r  <= 32'h0000_0000;
      frames_done_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      // code latched at comma: last bit is the last valid sample before the comma cycle
      if (state_r == ST_COMMA) begin
        frame_code_r <= timecode;
      end
      if ((state_r == ST_BODY) && (state_nxt == ST_IDLE)) begin
        frame_cnt_r   <= frame_cnt_r + 32'h1;
        frames_done_r <= frames_done_r + 32'h1;
      end
    end
  end

  // ============================================================
  // one lane stage per path
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      sff_lane_tx u_lane (
        .core_clk_in   (core_clk_in),
        .rst_b_in      (rst_b_in),
        .byte_in       (tx_byte[8*g +: 8]),
        .is_k_in       (tx_k),
        .lane_byte_out (lane_byte_out[8*g +: 8]),
        .lane_k_out    (lane_k_out[g])
      );
    end
  endgenerate
endmodule // sff_frame_formatter

// ==== bench/sff_frame_formatter_assertions.sv ====
// ============================================================
// checker: lane framing and bus wait behaviour
module sff_fmt_chk #(
  parameter LANES = 2
) (
  input wire               core_clk_in,
  input wire               rst_b_in,
  input wire               avs_read_in,
  input wire               avs_write_in,
  input wire               avs_waitrequest_out,
  input wire               body_req_out,
  input wire               frame_start_out,
  input wire [8*LANES-1:0] lane_byte_out,
  input wire [LANES-1:0]   lane_k_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [7:0] b0 = lane_byte_out[7:0];  // lane 0 stands for all lanes
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_comma_opens: assert property (
    frame_start_out |=> lane_k_out[0] && b0 == 8'hfc) else $error("no comma");
  a_idle_fill: assert property (
    lane_k_out[0] |-> b0 == 8'hfc || b0 == 8'hf7) else $error("bad k char");
  a_marker_first: assert property (
    frame_start_out |-> ##2 !lane_k_out[0] && b0 == 8'h5a) else $error("marker");
  a_version_next: assert property (
    frame_start_out |-> ##3 b0 == 8'h01) else $error("version byte");
  a_flags_upper: assert property (
    frame_start_out |-> ##4 b0[7:2] == 6'h00) else $error("flags upper bits");
  a_fft_length: assert property (
    frame_start_out |-> ##5 b0 == 8'h12) else $error("length byte");
  a_state_zeros: assert property (
    frame_start_out |-> ##6 b0[3:2] == 2'b00) else $error("state gap bits");
  a_body_follows: assert property (
    frame_start_out |-> ##25 body_req_out [*8]) else $error("body not next");
  a_body_data: assert property (
    body_req_out |=> !lane_k_out[0]) else $error("k char in body");
  a_lanes_agree: assert property (
    lane_k_out == {LANES{lane_k_out[0]}}) else $error("lanes out of step");
  a_read_wait: assert property (
    avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("read wait too long");
  a_write_nowait: assert property (
    avs_write_in |-> !avs_waitrequest_out) else $error("write stalled");
endmodule // sff_fmt_chk

bind sff_frame_formatter sff_fmt_chk #(.LANES(LANES)) i_chk (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .body_req_out(body_req_out),
  .frame_start_out(frame_start_out), .lane_byte_out(lane_byte_out),
  .lane_k_out(lane_k_out));

// ==== bench/sff_lane_rx.sv ====
// ============================================================
// downstream lane receiver: parses one lane into header and body
module sff_lane_rx (
  input  wire         core_clk_in,
  input  wire         rst_b_in,
  input  wire [7:0]   byte_in,
  input  wire         k_in,
  output reg  [191:0] hdr_out,
  output reg  [15:0]  body_cnt_out,
  output reg  [15:0]  body_err_out,
  output reg  [7:0]   frames_out
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [15:0] pos_r;   // byte index in frame, ffff when idle
  reg [7:0]  last_r;  // previous byte, body must count up
  // receiver only trusts the comma to find frame starts
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pos_r      <= 16'hffff;
      frames_out <= 8'h0;
    end else if (k_in && byte_in == 8'hfc) begin
      pos_r        <= 16'h0;
      body_cnt_out <= 16'h0;
      body_err_out <= 16'h0;
    end else if (k_in) begin
      if (pos_r != 16'hffff)
        frames_out <= frames_out + 8'h01;
      pos_r <= 16'hffff;
    end else if (pos_r != 16'hffff) begin
      pos_r  <= pos_r + 16'h1;
      last_r <= byte_in;
      if (pos_r < 16'd24)
        hdr_out <= {hdr_out[183:0], byte_in};
      else
        body_cnt_out <= body_cnt_out + 16'h1;
      // a gap or reorder in the body breaks the running count
      if (pos_r > 16'd24 && byte_in !== last_r + 8'h01)
        body_err_out <= body_err_out + 16'h1;
    end
  end
endmodule // sff_lane_rx

// ==== bench/sff_frame_formatter_tb.sv ====
module sff_frame_formatter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // nets
  logic         core_clk_in      = 1'b0;
  logic         rst_b_in         = 1'b0;
  logic [3:0]   avs_address_in   = 4'h0;
  logic         avs_read_in      = 1'b0;
  logic         avs_write_in     = 1'b0;
  logic [31:0]  avs_writedata_in = 32'h0;
  logic [27:0]  sample_word_in   = 28'h0;
  logic         sample_valid_in  = 1'b0;
  logic [7:0]   bb               = 8'h0;  // body byte, steps every cycle
  logic [31:0]  avs_readdata_out;
  logic         avs_waitrequest_out;
  logic         body_req_out;
  logic         frame_start_out;
  logic [15:0]  lane_byte_out;
  logic [1:0]   lane_k_out;
  logic [191:0] hdr;
  logic [15:0]  body_cnt;
  logic [15:0]  body_err;
  logic [7:0]   frames;
  logic [31:0]  q;
  int           errors    = 0;
  int           cmp_count = 0;
  int           cycles    = 0;
  sff_frame_formatter #(.LANES(2), .WORD_BITS(28)) i_dut (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .sample_word_in(sample_word_in), .sample_valid_in(sample_valid_in),
    .body_byte_in({~bb, bb}), .body_ready_in(1'b1),
    .body_req_out(body_req_out), .frame_start_out(frame_start_out),
    .lane_byte_out(lane_byte_out), .lane_k_out(lane_k_out));
  sff_lane_rx i_rx (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .byte_in(lane_byte_out[7:0]), .k_in(lane_k_out[0]), .hdr_out(hdr),
    .body_cnt_out(body_cnt), .body_err_out(body_err), .frames_out(frames));
  // ============================================================
  // clock, body source and hang guard (two frames need ~66k cycles)
  always #5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    bb     <= bb + 8'h01;
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors = errors + 1;
      tally_and_finish();
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // avalon master: hold until waitrequest is seen low at an edge
  task bus(input rd, input [3:0] a, input [31:0] d, output [31:0] r);
    @(posedge core_clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_read_in      <= rd;
    avs_write_in     <= !rd;
    // waitrequest and readdata seen as they stood at this edge
    do
      @(posedge core_clk_in);
    while (avs_waitrequest_out !== 1'b0);
    r = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task wait_frames(input [7:0] n);
    for (int i = 0; i < 40000 && frames !== n; i++)
      @(posedge core_clk_in);
    chk(frames, n);
  endtask
  // ============================================================
  // scenarios
  task t_regs;
    @(negedge core_clk_in);
    chk({lane_k_out, lane_byte_out}, 32'h3f7f7);
    bus(1'b0, 4'h2, 32'h89abcdef, q);
    bus(1'b0, 4'h3, 32'h01234567, q);
    bus(1'b0, 4'h4, 32'hffffffff, q);
    bus(1'b1, 4'h3, 32'h0, q);
    chk(q, 32'h01234567);
    bus(1'b1, 4'h4, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b1, 4'hf, 32'h0, q);
    chk(q, 32'h0);
  endtask
  // only the top bit of each valid word may reach the time code
  task t_timecode;
    logic [31:0] tc;
    tc = 32'hc3a50f1e;
    for (int i = 0; i < 32; i++) begin
      @(posedge core_clk_in);
      sample_word_in  <= {tc[31-i], 27'h5555555};
      sample_valid_in <= 1'b1;
    end
    @(posedge core_clk_in);
    sample_valid_in <= 1'b0;
    bus(1'b1, 4'h5, 32'h0, q);
    chk(q, tc);
  endtask
  task t_frames;
    bus(1'b0, 4'h0, 32'h2a512353, q);
    bus(1'b1, 4'h1, 32'h0, q);
    chk(q, 32'hd2a5);
    wait_frames(8'h01);
    chk(hdr[191:160], 32'h5a010112);
    chk(hdr[159:128], 32'hd2a50123);
    chk(hdr[127:96], 32'h01234567);
    chk(hdr[95:64], 32'h89abcdef);
    chk(hdr[63:32], 32'h0);
    chk(hdr[31:0], 32'hc3a50f1e);
    chk(body_cnt, 32'h8000);
    chk(body_err, 32'h0);
    bus(1'b0, 4'h0, 32'h0, q);
    wait_frames(8'h02);
    chk(hdr[63:32], 32'h1);
    chk(body_err, 32'h0);
    repeat (40) @(posedge core_clk_in);
    @(negedge core_clk_in);
    chk({frames, lane_k_out[0], lane_byte_out[7:0]}, 32'h5f7);
    bus(1'b1, 4'h4, 32'h0, q);
    chk(q, 32'h2);
  endtask
  task tally_and_finish;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    t_regs();
    t_timecode();
    t_frames();
    tally_and_finish();
  end
endmodule // sff_frame_formatter_tb
